// *** pfd_frame_decoder.v ***
`timescale 1ns/1ps
`include "pfd_consts.vh"
// decoder and access guard for the three peripheral frames
// edge 0 takes cpu_req and the guard decides at once
// ack, with err on a refused access, frame select and strobe then stand one cycle
// read data is latched one edge later from the selected bus
// registered buses keep the guard off the peripheral paths,
// at the cost of one cycle of latency per access
// emulation registers sit inside, not on a frame bus
// requests may come on every cycle; nothing is queued

module pfd_frame_decoder #(
    parameter [15:0] ID_VALUE   = `PFD_ID_DEFAULT,
    parameter [31:0] CAN_PROT_M = 32'h0000FFFF
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst,

    // processor access port
    input  wire        cpu_req,
    input  wire        cpu_we,
    input  wire        cpu_wide,
    input  wire [21:0] cpu_addr,
    input  wire [31:0] cpu_wdata,
    output reg  [31:0] cpu_rdata,
    output reg         cpu_ack,
    output reg         cpu_err,

    // instruction events from the processor
    input  wire        write_unlock_instr,
    input  wire        write_lock_instr,

    // code security module state
    input  wire        code_security_unlocked,

    // frame zero memory bus
    output reg         f0_sel,
    output reg         f0_we,
    output reg         f0_wide,
    output reg  [21:0] f0_addr,
    output reg  [31:0] f0_wdata,
    input  wire [31:0] f0_rdata,

    // frame one 32-bit peripheral bus
    output reg         f1_sel,
    output reg         f1_we,
    output reg  [21:0] f1_addr,
    output reg  [31:0] f1_wdata,
    output reg  [31:0] f1_wmask,
    input  wire [31:0] f1_rdata,

    // frame two 16-bit peripheral bus
    output reg         f2_sel,
    output reg         f2_we,
    output reg  [21:0] f2_addr,
    output reg  [15:0] f2_wdata,
    input  wire [15:0] f2_rdata,

    // status
    output wire        unlock_state,
    output wire [31:0] device_configuration,
    output wire [15:0] block_protect_start,
    output wire [15:0] block_protect_range
);

    // decode results
    wire        in_f0;
    wire        in_f1;
    wire        in_f2;
    wire        mapped;
    wire        is_emu;
    wire        is_flash;
    wire        is_can_ctl;
    wire        prot;

    // emulation register read data
    wire [31:0] emu_rdata;

    // guard state and decisions
    reg         unlock_q;        // write unlock state
    reg         ok;              // access allowed to proceed
    reg         wr_ok;           // write allowed to land
    reg         emu_wr;          // emulation write strobe

    // read return tracking
    reg         pend;            // read result to capture next cycle
    reg         pend_wide;       // width of that read
    reg  [2:0]  pend_src;        // which source to capture
    reg  [31:0] pend_emu;        // emulation read held across the cycle

    // source codes for the read return, one-hot
    // zero selects the held emulation or refused data
    localparam [2:0] SRC_F0 = 3'b001;
    localparam [2:0] SRC_F1 = 3'b010;
    localparam [2:0] SRC_F2 = 3'b100;

    // trim read data to the access width; a narrow read must not
    // leak the upper word of a 32-bit register onto the bus
    function [31:0] fit_width;
        input        wide;
        input [31:0] data;
        begin
            fit_width = wide ? data : {16'h0000, data[15:0]};
        end
    endfunction

    // the unlock state is shown as is, for software and debug
    assign unlock_state = unlock_q;

    // address map, combinational from the request address
    pfd_region_decode u_dec (
        .addr       (cpu_addr),
        .in_f0      (in_f0),
        .in_f1      (in_f1),
        .in_f2      (in_f2),
        .mapped     (mapped),
        .is_emu     (is_emu),
        .is_flash   (is_flash),
        .is_can_ctl (is_can_ctl),
        .prot       (prot)
    );

    // emulation registers live here, not out on the bus
    // a locked write to them never shows as a frame zero strobe
    // and their read data is taken in the request cycle
    pfd_emu_regs #(
        .ID_VALUE (ID_VALUE)
    ) u_emu (
        .clk_sys              (clk_sys),
        .rst                  (rst),
        .sel                  (emu_wr),
        .wr_en                (emu_wr),
        .wide                 (cpu_wide),
        .addr                 (cpu_addr),
        .wdata                (cpu_wdata),
        .rdata                (emu_rdata),
        .device_configuration (device_configuration),
        .block_protect_start  (block_protect_start),
        .block_protect_range  (block_protect_range)
    );

    // unlock state; lock wins if both arrive together, the safe side
    // one unlock opens every protected region at once (flash also needs code security unlocked);
    // there is no per-region unlock; software must lock again when it is done
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            unlock_q <= 1'b0;
        end else if (write_lock_instr) begin
            unlock_q <= 1'b0;
        end else if (write_unlock_instr) begin
            unlock_q <= 1'b1;
        end
    end

    // access guard, decided from the live request in the same cycle
    // a refused access never reaches a bus, so no peripheral ever
    // sees a request that the guard later takes back
    always @* begin
        // reserved and unmapped addresses are refused first
        ok    = cpu_req && mapped;

        // can control rejects narrow accesses outright
        if (in_f1 && is_can_ctl && !cpu_wide) begin
            ok = 1'b0;
        end

        // frame two drops every wide access
        if (in_f2 && cpu_wide) begin
            ok = 1'b0;
        end

        // flash is closed entirely unless both conditions hold
        if (is_flash && !(unlock_q && code_security_unlocked)) begin
            ok = 1'b0;
        end

        // protected writes need the unlock state; emu group included
        // a blocked write is still acknowledged, only its effect is lost
        wr_ok  = ok && cpu_we && (!prot || unlock_q);
        emu_wr = wr_ok && is_emu;
    end

    // bus drive, one cycle per access; the processor keeps its own alignment
    // address and data follow the request every cycle; only sel and we
    // qualify them, which saves enables on the wide data registers
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            // frame zero idle
            f0_sel   <= 1'b0;
            f0_we    <= 1'b0;
            f0_wide  <= 1'b0;
            f0_addr  <= 22'h000000;
            f0_wdata <= 32'h00000000;
            // frame one idle
            f1_sel   <= 1'b0;
            f1_we    <= 1'b0;
            f1_addr  <= 22'h000000;
            f1_wdata <= 32'h00000000;
            f1_wmask <= 32'h00000000;
            // frame two idle
            f2_sel   <= 1'b0;
            f2_we    <= 1'b0;
            f2_addr  <= 22'h000000;
            f2_wdata <= 16'h0000;
        end else begin
            // frame zero straight off the memory bus, both widths
            f0_sel   <= ok && in_f0 && !is_emu;
            f0_we    <= wr_ok && in_f0 && !is_emu;
            f0_wide  <= cpu_wide;
            f0_addr  <= cpu_addr;
            f0_wdata <= cpu_wdata;

            // frame one on the 32-bit bus
            f1_sel   <= ok && in_f1;
            f1_we    <= ok && in_f1 && cpu_we;
            f1_addr  <= cpu_addr;
            f1_wdata <= cpu_wdata;

            // locked: only unprotected bits of control words change
            if (is_can_ctl && !unlock_q) begin
                f1_wmask <= ~CAN_PROT_M;
            end else if (cpu_wide) begin
                f1_wmask <= 32'hFFFFFFFF;
            end else begin
                f1_wmask <= 32'h0000FFFF;
            end

            // frame two on the 16-bit bus
            f2_sel   <= ok && in_f2;
            f2_we    <= wr_ok && in_f2;
            f2_addr  <= cpu_addr;
            // only the low half travels on the narrow bus
            f2_wdata <= cpu_wdata[15:0];
        end
    end

    // read return tracking; emulation data captured with the request
    // only reads set pend, so cpu_rdata keeps the last read result
    // across any writes that follow it
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pend      <= 1'b0;
            pend_wide <= 1'b0;
            pend_src  <= 3'b000;
            pend_emu  <= 32'h00000000;
            cpu_ack   <= 1'b0;
            cpu_err   <= 1'b0;
        end else begin
            pend      <= cpu_req && !cpu_we;
            pend_wide <= cpu_wide;
            // every request is answered, refused ones included
            cpu_ack   <= cpu_req;
            // refused or reserved accesses flag an error, data zero
            cpu_err   <= cpu_req && !ok;
            pend_emu  <= (ok && is_emu) ? emu_rdata : 32'h00000000;

            // refused reads and emulation reads return pend_emu
            if (!ok || cpu_we || is_emu) begin
                pend_src <= 3'b000;
            end else if (in_f0) begin
                pend_src <= SRC_F0;
            end else if (in_f1) begin
                pend_src <= SRC_F1;
            end else begin
                pend_src <= SRC_F2;
            end
        end
    end

    // read data: the selected bus replies in the same cycle that sel stands
    // the peripheral answer is not registered on its side, so bus
    // read data must settle within one clock period
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cpu_rdata <= 32'h00000000;
        end else if (pend) begin
            case (pend_src)
                SRC_F0:  cpu_rdata <= fit_width(pend_wide, f0_rdata);
                SRC_F1:  cpu_rdata <= fit_width(pend_wide, f1_rdata);
                SRC_F2:  cpu_rdata <= {16'h0000, f2_rdata};
                default: cpu_rdata <= pend_emu; // zero unless emulation
            endcase
        end
    end
endmodule

// *** pfd_consts.vh ***
`ifndef PFD_CONSTS_VH
`define PFD_CONSTS_VH
// word addresses (16-bit words) of the frames and regions
`define PFD_AW              22
`define PFD_F0_LO           22'h000800
`define PFD_F0_HI           22'h000FFF
`define PFD_EMU_LO          22'h000880
`define PFD_EMU_HI          22'h0009FF
`define PFD_FLASH_LO        22'h000A80
`define PFD_FLASH_HI        22'h000ADF
`define PFD_KEY_LO          22'h000AE0
`define PFD_KEY_HI          22'h000AEF
`define PFD_EXT_LO          22'h000B20
`define PFD_EXT_HI          22'h000B3F
`define PFD_TMR_LO          22'h000C00
`define PFD_TMR_HI          22'h000C3F
`define PFD_IRQ_LO          22'h000CE0
`define PFD_IRQ_HI          22'h000CFF
`define PFD_VEC_LO          22'h000D00
`define PFD_VEC_HI          22'h000DFF
`define PFD_F1_LO           22'h006000
`define PFD_F1_HI           22'h006FFF
`define PFD_CAN_LO          22'h006000
`define PFD_CAN_HI          22'h0060FF
`define PFD_MBX_LO          22'h006100
`define PFD_MBX_HI          22'h0061FF
`define PFD_F2_LO           22'h007000
`define PFD_F2_HI           22'h007FFF
// frame two peripheral windows
`define PFD_SYS_LO          22'h007010
`define PFD_SYS_HI          22'h00702F
`define PFD_SER_LO          22'h007040
`define PFD_SER_HI          22'h00705F
`define PFD_XIR_LO          22'h007070
`define PFD_XIR_HI          22'h00707F
`define PFD_GPM_LO          22'h0070C0
`define PFD_GPM_HI          22'h0070DF
`define PFD_ADC_HI          22'h00711F
`define PFD_MCA_LO          22'h007400
`define PFD_MCA_HI          22'h00743F
`define PFD_MCB_LO          22'h007500
`define PFD_MCB_HI          22'h00753F
`define PFD_SCB_LO          22'h007750
`define PFD_SCB_HI          22'h00775F
`define PFD_SRL_LO          22'h007800
`define PFD_SRL_HI          22'h00783F
// emulation registers
`define PFD_CFG_LO_ADDR     22'h000880
`define PFD_CFG_HI_ADDR     22'h000881
`define PFD_RSVD_ADDR       22'h000882
`define PFD_ID_ADDR         22'h000883
`define PFD_PSTART_ADDR     22'h000884
`define PFD_PRANGE_ADDR     22'h000885
// reset values
`define PFD_CFG_RST         32'h00000000
`define PFD_PSTART_RST      16'h0000
`define PFD_PRANGE_RST      16'h0000
// arbitrary identification value
`define PFD_ID_DEFAULT      16'h00A5
`endif

// *** pfd_region_decode.v ***
`timescale 1ns/1ps
// combinational map of a word address onto frame, region and protection
module pfd_region_decode (
    // address in
    input  wire [21:0] addr,
    // frame selects
    output reg         in_f0,
    output reg         in_f1,
    output reg         in_f2,
    // region attributes
    output reg         mapped,
    output reg         is_emu,
    output reg         is_flash,
    output reg         is_can_ctl,
    output reg         prot
);
`include "pfd_consts.vh"

    // inclusive range test, used for every region
    function in_rng;
        input [21:0] a;
        input [21:0] lo;
        input [21:0] hi;
        begin
            in_rng = (a >= lo) && (a <= hi);
        end
    endfunction

    // frame 2 peripheral windows, all 16-word aligned
    function f2_mapped;
        input [21:0] a;
        begin
            f2_mapped = in_rng(a, `PFD_SYS_LO, `PFD_SYS_HI) || in_rng(a, `PFD_SER_LO, `PFD_SER_HI) ||
                        in_rng(a, `PFD_XIR_LO, `PFD_XIR_HI) || in_rng(a, `PFD_GPM_LO, `PFD_ADC_HI) ||
                        in_rng(a, `PFD_MCA_LO, `PFD_MCA_HI) || in_rng(a, `PFD_MCB_LO, `PFD_MCB_HI) ||
                        in_rng(a, `PFD_SCB_LO, `PFD_SCB_HI) || in_rng(a, `PFD_SRL_LO, `PFD_SRL_HI);
        end
    endfunction

    // region classification
    always @* begin
        in_f0      = in_rng(addr, `PFD_F0_LO, `PFD_F0_HI);
        in_f1      = in_rng(addr, `PFD_F1_LO, `PFD_F1_HI);
        in_f2      = in_rng(addr, `PFD_F2_LO, `PFD_F2_HI);
        is_emu     = in_rng(addr, `PFD_EMU_LO, `PFD_EMU_HI);
        is_flash   = in_rng(addr, `PFD_FLASH_LO, `PFD_FLASH_HI);
        is_can_ctl = in_rng(addr, `PFD_CAN_LO, `PFD_CAN_HI);
        // protected regions: emulation, flash, key words, vectors, system, gpio mux
        prot       = is_emu || is_flash ||
                     in_rng(addr, `PFD_KEY_LO, `PFD_KEY_HI) ||
                     in_rng(addr, `PFD_VEC_LO, `PFD_VEC_HI) ||
                     in_rng(addr, `PFD_SYS_LO, `PFD_SYS_HI) || in_rng(addr, `PFD_GPM_LO, `PFD_GPM_HI);
        // anything outside these windows is reserved
        mapped     = is_emu || is_flash || in_rng(addr, `PFD_KEY_LO, `PFD_KEY_HI) ||
                     in_rng(addr, `PFD_EXT_LO, `PFD_EXT_HI) || in_rng(addr, `PFD_TMR_LO, `PFD_TMR_HI) ||
                     in_rng(addr, `PFD_IRQ_LO, `PFD_VEC_HI) || in_rng(addr, `PFD_CAN_LO, `PFD_MBX_HI) ||
                     (in_f2 && f2_mapped(addr));
    end
endmodule

// *** pfd_emu_regs.v ***
`timescale 1ns/1ps
`include "pfd_consts.vh"
// device emulation register group
module pfd_emu_regs #(
    parameter [15:0] ID_VALUE = `PFD_ID_DEFAULT
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // access from the decoder
    input  wire        sel,
    input  wire        wr_en,
    input  wire        wide,
    input  wire [21:0] addr,
    input  wire [31:0] wdata,
    // read data, device configuration and block protection outputs
    output reg  [31:0] rdata,
    output reg  [31:0] device_configuration,
    output reg  [15:0] block_protect_start,
    output reg  [15:0] block_protect_range
);

    // writes land only when the decoder already passed the guard
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            device_configuration <= `PFD_CFG_RST;
            block_protect_start  <= `PFD_PSTART_RST;
            block_protect_range  <= `PFD_PRANGE_RST;
        end else if (sel && wr_en) begin
            case (addr)
                `PFD_CFG_LO_ADDR: begin
                    device_configuration[15:0] <= wdata[15:0];
                    // a wide access fills the upper word too
                    if (wide) begin
                        device_configuration[31:16] <= wdata[31:16];
                    end
                end
                `PFD_CFG_HI_ADDR: device_configuration[31:16] <= wdata[15:0];
                `PFD_PSTART_ADDR: block_protect_start <= wdata[15:0];
                `PFD_PRANGE_ADDR: block_protect_range <= wdata[15:0];
                default: ; // reserved word 0x882 and the rest ignore writes
            endcase
        end
    end

    // read mux, reserved words read zero
    always @* begin
        case (addr)
            `PFD_CFG_LO_ADDR: rdata = wide ? device_configuration : {16'h0000, device_configuration[15:0]};
            `PFD_CFG_HI_ADDR: rdata = {16'h0000, device_configuration[31:16]};
            `PFD_ID_ADDR:     rdata = {16'h0000, ID_VALUE};
            `PFD_PSTART_ADDR: rdata = {16'h0000, block_protect_start};
            `PFD_PRANGE_ADDR: rdata = {16'h0000, block_protect_range};
            default:          rdata = 32'h00000000;
        endcase
    end
endmodule

// *** pfd_checker_assertions.sv ***
`timescale 1ns/1ps
`include "pfd_consts.vh"
// watches the decoder ports for routing and guard timing
module pfd_checker (
    // clock and reset
    input wire        clk_sys,
    input wire        rst,
    // processor side
    input wire        cpu_req,
    input wire        cpu_we,
    input wire        cpu_wide,
    input wire [21:0] cpu_addr,
    input wire [31:0] cpu_rdata,
    input wire        cpu_ack,
    input wire        cpu_err,
    input wire        write_lock_instr,
    input wire        code_security_unlocked,
    input wire        unlock_state,
    // frame buses
    input wire        f0_sel,
    input wire        f0_we,
    input wire        f1_sel,
    input wire [31:0] f1_wmask,
    input wire        f2_sel
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // region hits of the current request address
    wire fl  = cpu_addr >= `PFD_FLASH_LO && cpu_addr <= `PFD_FLASH_HI;
    wire key = cpu_addr >= `PFD_KEY_LO && cpu_addr <= `PFD_KEY_HI;
    wire can = cpu_addr >= `PFD_CAN_LO && cpu_addr <= `PFD_CAN_HI;
    wire mbx = cpu_addr >= `PFD_MBX_LO && cpu_addr <= `PFD_MBX_HI;
    wire fr2 = cpu_addr >= `PFD_F2_LO && cpu_addr <= `PFD_F2_HI;
    wire tmr = cpu_addr >= `PFD_TMR_LO && cpu_addr <= `PFD_TMR_HI;
    // reserved holes of frame zero, below flash and at the top
    wire rsv = (cpu_addr >= 22'h000A00 && cpu_addr <= 22'h000A7F) ||
               (cpu_addr >= 22'h000E00 && cpu_addr <= `PFD_F0_HI);

    AST_ACK_FOLLOWS: assert property (cpu_req |=> cpu_ack) else $error("no ack after request");
    AST_NO_STRAY_ACK: assert property (!cpu_req |=> !cpu_ack && !cpu_err) else $error("ack without request");
    AST_FLASH_GUARD: assert property (cpu_req && fl && !(unlock_state && code_security_unlocked)
        |=> cpu_err && !f0_sel) else $error("flash reached while guarded");
    AST_KEY_LOCKED: assert property (cpu_req && cpu_we && key && !unlock_state
        |=> cpu_ack && !cpu_err && !f0_we) else $error("locked key write went out");
    AST_LOCK_WINS: assert property (write_lock_instr |=> !unlock_state) else $error("lock did not clear");
    AST_CAN_NARROW: assert property (cpu_req && !cpu_wide && can |=> cpu_err && !f1_sel)
        else $error("narrow can access passed");
    AST_MBX_OPEN: assert property (cpu_req && cpu_we && cpu_wide && mbx |=> f1_sel && f1_wmask == 32'hFFFFFFFF)
        else $error("mailbox write masked");
    AST_F2_WIDE: assert property (cpu_req && cpu_wide && fr2 |=> cpu_err && !f2_sel)
        else $error("wide frame two access passed");
    AST_RSVD_ZERO: assert property (cpu_req && !cpu_we && rsv |=> cpu_err ##1 cpu_rdata == 32'h00000000)
        else $error("reserved read not zero");
    AST_F0_DIRECT: assert property (cpu_req && tmr |=> f0_sel && !f1_sel && !f2_sel)
        else $error("timer access misrouted");
endmodule
bind pfd_frame_decoder pfd_checker pfd_checker_i (.clk_sys(clk_sys), .rst(rst), .cpu_req(cpu_req),
    .cpu_we(cpu_we), .cpu_wide(cpu_wide), .cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack),
    .cpu_err(cpu_err), .write_lock_instr(write_lock_instr), .code_security_unlocked(code_security_unlocked),
    .unlock_state(unlock_state), .f0_sel(f0_sel), .f0_we(f0_we), .f1_sel(f1_sel), .f1_wmask(f1_wmask),
    .f2_sel(f2_sel));

// *** pfd_periph_model.sv ***
`timescale 1ns/1ps
// peripherals behind the three frame buses, answering while selected
module pfd_periph_model (
    // frame zero and one buses
    input  wire        f0_sel,
    input  wire [21:0] f0_addr,
    output wire [31:0] f0_rdata,
    input  wire        f1_sel,
    input  wire [21:0] f1_addr,
    output wire [31:0] f1_rdata,
    // frame two bus
    input  wire        f2_sel,
    input  wire [21:0] f2_addr,
    output wire [15:0] f2_rdata
);
    // idle buses show the inverse, so a late sample never matches
    assign f0_rdata = f0_sel ? {10'h2B5, f0_addr} : ~{10'h2B5, f0_addr};
    assign f1_rdata = f1_sel ? {10'h1C3, f1_addr} : ~{10'h1C3, f1_addr};
    assign f2_rdata = f2_sel ? f2_addr[15:0] ^ 16'h5AA5 : ~f2_addr[15:0];
endmodule

// *** pfd_frame_decoder_bench.sv ***
`timescale 1ns/1ps
`include "pfd_consts.vh"
// self-checking bench for the frame decoder
module pfd_frame_decoder_bench;
    reg         clk_sys, rst, cpu_req, cpu_we, cpu_wide, rw, rwide, r_ack, r_err;
    reg         write_unlock_instr, write_lock_instr, code_security_unlocked;
    reg  [21:0] cpu_addr, ra, r_ad;
    reg  [31:0] cpu_wdata, r_mask, r_wd, r_rd, d, e, m;
    reg  [2:0]  r_sel, r_we;
    wire [31:0] cpu_rdata, f0_wdata, f1_wdata, f1_wmask, f0_rdata, f1_rdata, device_configuration;
    wire        cpu_ack, cpu_err, f0_sel, f0_we, f0_wide, f1_sel, f1_we, f2_sel, f2_we, unlock_state;
    wire [21:0] f0_addr, f1_addr, f2_addr;
    wire [15:0] f2_wdata, f2_rdata, block_protect_start, block_protect_range;
    integer     mismatches, cmp_count, i, k, seed;

    // identification value is arbitrary
    pfd_frame_decoder #(.ID_VALUE(16'h005A), .CAN_PROT_M(32'h0000FFFF)) pfd_frame_decoder_i (
        .clk_sys(clk_sys), .rst(rst), .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_wide(cpu_wide),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack),
        .cpu_err(cpu_err), .write_unlock_instr(write_unlock_instr), .write_lock_instr(write_lock_instr),
        .code_security_unlocked(code_security_unlocked), .f0_sel(f0_sel), .f0_we(f0_we), .f0_wide(f0_wide),
        .f0_addr(f0_addr), .f0_wdata(f0_wdata), .f0_rdata(f0_rdata), .f1_sel(f1_sel), .f1_we(f1_we),
        .f1_addr(f1_addr), .f1_wdata(f1_wdata), .f1_wmask(f1_wmask), .f1_rdata(f1_rdata), .f2_sel(f2_sel),
        .f2_we(f2_we), .f2_addr(f2_addr), .f2_wdata(f2_wdata), .f2_rdata(f2_rdata),
        .unlock_state(unlock_state), .device_configuration(device_configuration),
        .block_protect_start(block_protect_start), .block_protect_range(block_protect_range));
    pfd_periph_model pfd_periph_model_i (.f0_sel(f0_sel), .f0_addr(f0_addr), .f0_rdata(f0_rdata),
        .f1_sel(f1_sel), .f1_addr(f1_addr), .f1_rdata(f1_rdata), .f2_sel(f2_sel), .f2_addr(f2_addr),
        .f2_rdata(f2_rdata));

    // expected peripheral read data for a frame and address
    function [31:0] pat(input integer f, input [21:0] x);
        pat = (f == 0) ? {10'h2B5, x} : (f == 1) ? {10'h1C3, x} : {16'h0000, x[15:0] ^ 16'h5AA5};
    endfunction
    // compare and count
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // one access from a falling edge; answer one cycle on, read data two
    task acc(input tw, input tv, input [21:0] ta, input [31:0] td);
        begin
            cpu_req = 1'b1;
            cpu_we = tw;
            cpu_wide = tv;
            cpu_addr = ta;
            cpu_wdata = td;
            @(negedge clk_sys);
            cpu_req = 1'b0;
            r_ack = cpu_ack;
            r_err = cpu_err;
            r_sel = {f2_sel, f1_sel, f0_sel};
            r_we = {f2_we, f1_we, f0_we};
            r_mask = f1_wmask;
            r_wd = f0_sel ? f0_wdata : f1_sel ? f1_wdata : {16'h0000, f2_wdata};
            r_ad = f0_sel ? f0_addr : f1_sel ? f1_addr : f2_addr;
            @(negedge clk_sys);
            r_rd = cpu_rdata;
        end
    endtask
    // one-cycle instruction pulses
    task pulse(input u, input l);
        begin
            write_unlock_instr = u;
            write_lock_instr = l;
            @(negedge clk_sys);
            write_unlock_instr = 1'b0;
            write_lock_instr = 1'b0;
        end
    endtask
    // verdict
    task end_sim;
        begin
            $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
            if (mismatches == 0 && cmp_count > 0) begin
                $display("STATUS OK");
            end else begin
                $display("STATUS NOT OK");
            end
            $finish;
        end
    endtask

    // clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches = mismatches + 1;
        end_sim;
    end
    // main sequence
    initial begin
        rst = 1'b1;
        {cpu_req, cpu_we, cpu_wide, write_unlock_instr, write_lock_instr, code_security_unlocked} = 6'h00;
        cpu_addr = 22'h000000;
        cpu_wdata = 32'h00000000;
        mismatches = 0;
        cmp_count = 0;
        seed = $urandom(1);
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        chk(unlock_state, 0);
        chk(device_configuration, 0);
        chk({block_protect_start, block_protect_range}, 0);
        acc(0, 0, `PFD_ID_ADDR, 0);
        chk(r_rd[15:0], 16'h005A);
        acc(1, 0, `PFD_PSTART_ADDR, 32'h00001234);
        chk({r_ack, r_err, block_protect_start}, {2'b10, 16'h0000});
        pulse(1, 0);
        acc(1, 0, `PFD_PSTART_ADDR, 32'h00001234);
        acc(1, 0, `PFD_PRANGE_ADDR, 32'h000000C0);
        chk(block_protect_start, 16'h1234);
        acc(0, 0, `PFD_PRANGE_ADDR, 0);
        chk(r_rd[15:0], 16'h00C0);
        acc(1, 1, `PFD_CFG_LO_ADDR, 32'hCAFE5A5A);
        acc(0, 1, `PFD_CFG_LO_ADDR, 0);
        chk(r_rd, 32'hCAFE5A5A);
        acc(1, 0, `PFD_RSVD_ADDR, 32'h0000FFFF);
        acc(0, 0, `PFD_RSVD_ADDR, 0);
        chk(r_rd, 0);
        acc(1, 0, `PFD_KEY_LO + 22'h3, 32'h00000077);
        chk(r_we, 3'b001);
        pulse(1, 1);
        chk(unlock_state, 0);
        acc(1, 0, `PFD_PRANGE_ADDR, 32'h00000001);
        chk(block_protect_range, 16'h00C0);
        acc(1, 0, `PFD_KEY_HI, 32'h00000055);
        chk({r_ack, r_err, r_we}, 5'b10000);
        for (i = 0; i < 4; i = i + 1) begin
            code_security_unlocked = i[0];
            pulse(i[1], !i[1]);
            acc(0, 0, `PFD_FLASH_LO, 0);
            chk({r_err, r_sel}, (i == 3) ? 4'b0001 : 4'b1000);
        end
        pulse(0, 1);
        acc(0, 0, `PFD_CAN_LO, 0);
        chk({r_err, r_sel}, 4'b1000);
        acc(1, 1, `PFD_CAN_LO + 22'h2, $urandom);
        chk(r_mask, 32'hFFFF0000);
        acc(0, 1, 22'h007040, 0);
        chk({r_err, r_sel}, 4'b1000);
        for (i = 0; i < 40; i = i + 1) begin
            k = $urandom % 3;
            e = $urandom;
            d = $urandom;
            rw = e[0];
            rwide = (k == 1) || (k == 0 && e[1]);
            ra = (k == 0) ? {16'h0030, e[7:2]} : (k == 1) ? {14'h0061, e[9:2]} : {17'h00382, e[6:2]};
            ra[0] = ra[0] & !rwide;
            acc(rw, rwide, ra, d);
            m = rwide ? 32'hFFFFFFFF : 32'h0000FFFF;
            chk({r_err, r_sel}, 4'b0001 << k);
            if (rw) chk(r_we, 3'b001 << k);
            if (!rw) chk(r_rd & m, pat(k, ra) & m);
            if (rw) chk(r_wd & m, d & m);
            if (k == 0) chk(f0_wide, rwide);
            chk(r_ad, ra);
            if (rw && k == 1) chk(r_mask, 32'hFFFFFFFF);
        end
        acc(0, 1, `PFD_TMR_LO, 0);
        chk(r_rd, pat(0, `PFD_TMR_LO));
        acc(0, 0, 22'h000A00, 0);
        chk({r_err, r_rd}, {1'b1, 32'h00000000});
        end_sim;
    end
endmodule
